// ===== hdl/itfm_pkg.sv
package itfm_pkg;
  localparam int unsigned NUM_TERM = 6;
  localparam int unsigned ADDR_W = 4;
  localparam logic [7:0] FN_FORWARD_RUN = 8'h00;
  localparam logic [7:0] FN_REVERSE_RUN = 8'h01;
  localparam logic [7:0] FN_SPEED_BIT0 = 8'h02;
  localparam logic [7:0] FN_JOG_RUN = 8'h06;
  localparam logic [7:0] FN_DC_BRAKE = 8'h07;
  localparam logic [7:0] FN_MOTOR2 = 8'h08;
  localparam logic [7:0] FN_ALT_RAMP = 8'h09;
  localparam logic [7:0] FN_COAST_STOP = 8'h0B;
  localparam logic [7:0] FN_OUTSIDE_TRIP = 8'h0C;
  localparam logic [7:0] FN_TRIP_RESET = 8'h12;
  localparam logic [7:0] POL_ACTIVE_HIGH = 8'h00;
  localparam logic [7:0] POL_ACTIVE_LOW = 8'h01;
  localparam logic [7:0] TRIP_ERROR_CODE = 8'h0C;
  // Register indices; each terminal takes a consecutive index
  localparam logic [ADDR_W-1:0] REG_FUNC0 = 4'h0;
  localparam logic [ADDR_W-1:0] REG_POL0 = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'hC;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 4'hD;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 4'hE;
  localparam logic [ADDR_W-1:0] REG_TRIP = 4'hF;
  localparam int unsigned EV_TRIP = 0;
  localparam int unsigned EV_RUN_CHANGE = 1;
  localparam int unsigned NUM_EV = 2;
  localparam logic [7:0] FUNC_RESET [NUM_TERM] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h12, 8'h09};
  localparam logic [7:0] POL_RESET = 8'h00;

  typedef enum logic [1:0] {ITFM_STOP, ITFM_RUN_FWD, ITFM_RUN_REV, ITFM_RUN_JOG} itfm_mode_t;

  typedef struct packed {
    logic forward_run;
    logic reverse_run;
    logic [3:0] speed_index;
    logic jog_run;
    logic external_dc_brake;
    logic motor2_select;
    logic alt_ramp_select;
    logic coast_stop;
    logic outside_trip_request;
    logic trip_reset_command;
  } itfm_func_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } itfm_bus_t;
endpackage

// ===== hdl/itfm_sync.sv
`timescale 1ns/10ps
module itfm_sync
  import itfm_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Raw pins and clean levels
  input wire logic [NUM_TERM-1:0] i_pins,
  output logic [NUM_TERM-1:0] o_levels
);
  logic [NUM_TERM-1:0] meta_q;
  logic [NUM_TERM-1:0] meta_d;
  logic [NUM_TERM-1:0] sync_q;
  logic [NUM_TERM-1:0] sync_d;

  always_comb begin
    meta_d = i_pins;
    sync_d = meta_q;
  end

  // Two stages; the first is read only by the second
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_levels = sync_q;
endmodule

// ===== hdl/itfm_top.sv
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module itfm_top
  import itfm_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Terminals
  input wire logic [NUM_TERM-1:0] i_terminal,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Drive commands
  output logic o_run,
  output logic o_reverse,
  output logic o_jog_run,
  output logic [3:0] o_speed_index,
  output logic o_external_dc_brake,
  output logic o_motor2_select,
  output logic o_alt_ramp_select,
  output logic o_coast_stop,
  output logic o_trip,
  output logic [7:0] o_error_code,
  output logic o_trip_reset_command,
  // Interrupt
  output logic o_irq
);
  itfm_bus_t bus;
  logic [NUM_TERM-1:0] levels;
  logic [NUM_TERM-1:0] asserted;
  itfm_func_t fn;
  logic [7:0] func_q [NUM_TERM];
  logic [7:0] func_d [NUM_TERM];
  logic [NUM_TERM-1:0] low_q;
  logic [NUM_TERM-1:0] low_d;
  logic trip_prev_q;
  logic trip_prev_d;
  logic trip_q;
  logic trip_d;
  logic [7:0] err_q;
  logic [7:0] err_d;
  logic [NUM_EV-1:0] stat_q;
  logic [NUM_EV-1:0] stat_d;
  logic [NUM_EV-1:0] en_q;
  logic [NUM_EV-1:0] en_d;
  logic [NUM_EV-1:0] ev;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  itfm_mode_t mode_q;
  itfm_mode_t mode_d;
  itfm_func_t out_q;
  itfm_func_t out_d;
  logic irq_q;
  logic irq_d;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  itfm_sync u_sync (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_pins(i_terminal),
    .o_levels(levels)
  );

  // Polarity is applied after synchronising so edges are clock aligned
  genvar t;
  generate
    for (t = 0; t < NUM_TERM; t++) begin : g_term
      assign asserted[t] = levels[t] ^ low_q[t];
    end
  endgenerate

  // Each function is the OR of every terminal carrying its code
  always_comb begin
    fn = '0;
    for (int i = 0; i < NUM_TERM; i++) begin
      unique case (func_q[i])
        FN_FORWARD_RUN: fn.forward_run = fn.forward_run | asserted[i];
        FN_REVERSE_RUN: fn.reverse_run = fn.reverse_run | asserted[i];
        FN_JOG_RUN: fn.jog_run = fn.jog_run | asserted[i];
        FN_DC_BRAKE: fn.external_dc_brake = fn.external_dc_brake | asserted[i];
        FN_MOTOR2: fn.motor2_select = fn.motor2_select | asserted[i];
        FN_ALT_RAMP: fn.alt_ramp_select = fn.alt_ramp_select | asserted[i];
        FN_COAST_STOP: fn.coast_stop = fn.coast_stop | asserted[i];
        FN_OUTSIDE_TRIP: fn.outside_trip_request = fn.outside_trip_request | asserted[i];
        FN_TRIP_RESET: fn.trip_reset_command = fn.trip_reset_command | asserted[i];
        default: begin
          // Codes 02..05 form the speed index, unsupported codes do nothing
          if (func_q[i] >= FN_SPEED_BIT0 && func_q[i] <= FN_SPEED_BIT0 + 8'h03) begin
            fn.speed_index[func_q[i][1:0] - 2'h2] = 1'b1 & (fn.speed_index[func_q[i][1:0] - 2'h2]
              | asserted[i]);
          end
        end
      endcase
    end
  end

  // Run mode
  always_comb begin
    mode_d = ITFM_STOP;
    if (fn.forward_run && fn.reverse_run) begin
      mode_d = ITFM_STOP;
    end else if (fn.forward_run) begin
      mode_d = ITFM_RUN_FWD;
    end else if (fn.reverse_run) begin
      mode_d = ITFM_RUN_REV;
    end else if (fn.jog_run) begin
      mode_d = ITFM_RUN_JOG;
    end
    out_d = fn;
  end

  // Trip latch: rising edge sets, only the reset command clears
  always_comb begin
    trip_prev_d = fn.outside_trip_request;
    trip_d = trip_q;
    err_d = err_q;
    if (fn.trip_reset_command) begin
      trip_d = 1'b0;
      err_d = 8'h00;
    end
    if (fn.outside_trip_request && !trip_prev_q) begin
      trip_d = 1'b1;
      err_d = TRIP_ERROR_CODE;
    end
  end

  // Register writes, status and interrupt
  always_comb begin
    func_d = func_q;
    low_d = low_q;
    en_d = en_q;
    ev = '0;
    ev[EV_TRIP] = fn.outside_trip_request && !trip_prev_q;
    ev[EV_RUN_CHANGE] = (mode_d != mode_q);
    stat_d = stat_q;
    if (bus.wr) begin
      for (int i = 0; i < NUM_TERM; i++) begin
        if (bus.addr == REG_FUNC0 + 4'(i)) begin
          func_d[i] = bus.wdata;
        end
        if (bus.addr == REG_POL0 + 4'(i)) begin
          // Reset command terminals stay active high
          low_d[i] = (bus.wdata == POL_ACTIVE_LOW) && (func_q[i] != FN_TRIP_RESET);
        end
      end
      for (int i = 0; i < NUM_TERM; i++) begin
        if (bus.addr == REG_FUNC0 + 4'(i) && bus.wdata == FN_TRIP_RESET) begin
          low_d[i] = 1'b0;
        end
      end
      if (bus.addr == REG_IRQ_EN) begin
        en_d = bus.wdata[NUM_EV-1:0];
      end
      if (bus.addr == REG_IRQ_CLR) begin
        stat_d = stat_q & ~bus.wdata[NUM_EV-1:0];
      end
    end
    // Set wins over a clear in the same cycle
    stat_d = stat_d | ev;
    irq_d = |(stat_d & en_d);
    rdata_d = 8'h00;
    if (bus.rd) begin
      for (int i = 0; i < NUM_TERM; i++) begin
        if (bus.addr == REG_FUNC0 + 4'(i)) begin
          rdata_d = func_q[i];
        end
        if (bus.addr == REG_POL0 + 4'(i)) begin
          rdata_d = low_q[i] ? POL_ACTIVE_LOW : POL_ACTIVE_HIGH;
        end
      end
      if (bus.addr == REG_STATUS) begin
        rdata_d = {6'h00, stat_q};
      end
      if (bus.addr == REG_IRQ_EN) begin
        rdata_d = {6'h00, en_q};
      end
      if (bus.addr == REG_TRIP) begin
        rdata_d = err_q;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NUM_TERM; i++) begin
        func_q[i] <= FUNC_RESET[i];
      end
      low_q <= '0;
      en_q <= '0;
      stat_q <= '0;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
      trip_prev_q <= 1'b0;
      trip_q <= 1'b0;
      err_q <= 8'h00;
      mode_q <= ITFM_STOP;
      out_q <= '0;
    end else begin
      func_q <= func_d;
      low_q <= low_d;
      en_q <= en_d;
      stat_q <= stat_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      trip_prev_q <= trip_prev_d;
      trip_q <= trip_d;
      err_q <= err_d;
      mode_q <= mode_d;
      out_q <= out_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_run = (mode_q != ITFM_STOP);
  assign o_reverse = (mode_q == ITFM_RUN_REV);
  assign o_jog_run = (mode_q == ITFM_RUN_JOG);
  assign o_speed_index = out_q.speed_index;
  assign o_external_dc_brake = out_q.external_dc_brake;
  assign o_motor2_select = out_q.motor2_select;
  assign o_alt_ramp_select = out_q.alt_ramp_select;
  assign o_coast_stop = out_q.coast_stop;
  assign o_trip = trip_q;
  assign o_error_code = err_q;
  assign o_trip_reset_command = out_q.trip_reset_command;
  assign o_irq = irq_q;
endmodule

// ===== verification/itfm_switch_bank.sv
`timescale 1ns/10ps
module itfm_switch_bank
  import itfm_pkg::*;
(
  // Clock and wanted contacts
  input wire logic i_clock,
  input wire logic [NUM_TERM-1:0] i_set,
  // Terminal pins
  output logic [NUM_TERM-1:0] o_pins
);
  initial o_pins = '0;
  // Contacts move off the edge, as real switches ignore the drive clock
  always @(posedge i_clock) o_pins <= #2 i_set;
endmodule

// ===== verification/itfm_top_monitor.sv
`timescale 1ns/10ps
module itfm_top_monitor
  import itfm_pkg::*;
(
  // Clock, reset and inputs
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [NUM_TERM-1:0] i_terminal,
  input wire logic i_wr,
  input wire logic i_rd,
  // Outputs
  input wire logic [7:0] o_rdata,
  input wire logic o_run,
  input wire logic o_reverse,
  input wire logic o_jog_run,
  input wire logic [3:0] o_speed_index,
  input wire logic o_coast_stop,
  input wire logic o_trip,
  input wire logic [7:0] o_error_code,
  input wire logic o_trip_reset_command
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  reverse_runs_a: assert property (o_reverse |-> o_run && !o_jog_run)
    else $error("reverse without run");
  jog_alone_a: assert property (o_jog_run |-> o_run && !o_reverse)
    else $error("jog mixed with direction");
  error_code_a: assert property (o_error_code == (o_trip ? TRIP_ERROR_CODE : 8'h00))
    else $error("error code wrong");
  trip_hold_a: assert property (o_trip && !o_trip_reset_command |=> o_trip || o_trip_reset_command)
    else $error("trip lost");
  read_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside slot");
  calm_inputs_a: assert property (($stable(i_terminal) && !i_wr) [*4] |->
    $stable(o_speed_index) && $stable(o_coast_stop))
    else $error("output moved without cause");
  run_cause_a: assert property ($rose(o_run) |-> $past(i_terminal, 3) != $past(i_terminal, 4)
    || $past(i_wr, 1) || $past(i_wr, 2))
    else $error("run without cause");
  reset_quiet_a: assert property (disable iff (1'b0)
    !i_reset_n && $past(!i_reset_n) |-> !o_run && !o_trip && o_rdata == 8'h00)
    else $error("output active in reset");
  cover property ($rose(o_trip));
  cover property (o_reverse);
  cover property (o_jog_run);
endmodule
bind itfm_top itfm_top_monitor itfm_top_monitor_i (.i_clock, .i_reset_n, .i_terminal, .i_wr,
  .i_rd, .o_rdata, .o_run, .o_reverse, .o_jog_run, .o_speed_index, .o_coast_stop, .o_trip,
  .o_error_code, .o_trip_reset_command);

// ===== verification/test_itfm_top.sv
`timescale 1ns/10ps
module test_itfm_top;
  import itfm_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic [NUM_TERM-1:0] pins_set = '0;
  logic [NUM_TERM-1:0] i_terminal;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [7:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata, o_error_code, rv;
  logic o_run, o_reverse, o_jog_run, o_external_dc_brake, o_motor2_select;
  logic o_alt_ramp_select, o_coast_stop, o_trip, o_trip_reset_command, o_irq;
  logic [3:0] o_speed_index;
  int mismatches = 0;
  int check_count = 0;
  // Pins and {run, reverse, speed, alt ramp} under the reset-time functions
  localparam logic [12:0] ROWS [6] = '{{6'h01, 7'h40}, {6'h02, 7'h60}, {6'h03, 7'h00},
    {6'h04, 7'h02}, {6'h08, 7'h04}, {6'h20, 7'h01}};
  // Code for terminal 0 and {jog, brake, motor 2, coast, speed bits 3:2}
  localparam logic [13:0] MAP [6] = '{{FN_JOG_RUN, 6'h20}, {FN_DC_BRAKE, 6'h10},
    {FN_MOTOR2, 6'h08}, {FN_COAST_STOP, 6'h04}, {8'h04, 6'h01}, {8'h05, 6'h02}};
  always #5 i_clock = ~i_clock;
  itfm_switch_bank itfm_switch_bank_i (.i_clock, .i_set(pins_set), .o_pins(i_terminal));
  itfm_top itfm_top_i (.i_clock, .i_reset_n, .i_terminal, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_run, .o_reverse, .o_jog_run, .o_speed_index, .o_external_dc_brake,
    .o_motor2_select, .o_alt_ramp_select, .o_coast_stop, .o_trip, .o_error_code,
    .o_trip_reset_command, .o_irq);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // Two sync stages plus the output flop, with margin for the switch bank
  task automatic put(input logic [NUM_TERM-1:0] p);
    @(posedge i_clock);
    pins_set <= p;
    repeat (6) @(posedge i_clock);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
    for (int k = 0; k < NUM_TERM; k++) begin
      rd(REG_FUNC0 + ADDR_W'(k), rv);
      chk(rv, FUNC_RESET[k]);
      rd(REG_POL0 + ADDR_W'(k), rv);
      chk(rv, POL_RESET);
    end
    $display("reset values done");
    foreach (ROWS[r]) begin
      put(ROWS[r][12:7]);
      chk({1'b0, o_run, o_reverse, o_speed_index, o_alt_ramp_select}, {1'b0, ROWS[r][6:0]});
    end
    $display("default map done");
    foreach (MAP[m]) begin
      wr(REG_FUNC0, MAP[m][13:6]);
      put(6'h01);
      chk({2'b00, o_jog_run, o_external_dc_brake, o_motor2_select, o_coast_stop,
        o_speed_index[3:2]}, {2'b00, MAP[m][5:0]});
      put(6'h00);
    end
    $display("remap done");
    wr(REG_FUNC0, FN_FORWARD_RUN);
    wr(REG_POL0, POL_ACTIVE_LOW);
    put(6'h00);
    chk({7'h00, o_run}, 8'h01);
    put(6'h01);
    chk({7'h00, o_run}, 8'h00);
    wr(REG_POL0, POL_ACTIVE_HIGH);
    wr(REG_FUNC0 + 4'h1, FN_FORWARD_RUN);
    put(6'h02);
    chk({6'h00, o_reverse, o_run}, 8'h01);
    put(6'h00);
    wr(REG_FUNC0, FN_TRIP_RESET);
    wr(REG_POL0, POL_ACTIVE_LOW);
    rd(REG_POL0, rv);
    chk(rv, POL_ACTIVE_HIGH);
    $display("polarity done");
    wr(REG_FUNC0 + 4'h2, FN_OUTSIDE_TRIP);
    wr(REG_IRQ_EN, 8'h01);
    put(6'h04);
    chk({6'h00, o_irq, o_trip}, 8'h03);
    chk(o_error_code, TRIP_ERROR_CODE);
    put(6'h00);
    chk({7'h00, o_trip}, 8'h01);
    wr(REG_IRQ_CLR, 8'h03);
    rd(REG_STATUS, rv);
    chk({rv[6:0], o_irq}, 8'h00);
    rd(REG_IRQ_CLR, rv);
    chk(rv, 8'h00);
    wr(REG_IRQ_EN, 8'h00);
    put(6'h04);
    rd(REG_STATUS, rv);
    chk({rv[0], o_irq, o_trip}, {5'h00, 3'h5});
    put(6'h10);
    chk({6'h00, o_trip_reset_command, o_trip}, 8'h02);
    chk(o_error_code, 8'h00);
    put(6'h00);
    $display("trip done");
    final_report();
  end
endmodule
